// *** mgmt_station_model.sv ***
/*
  station management controller model driving the serial bus.
  assumes a pull-up on the data line outside this model.
*/
module mgmt_station_model (
  // clock
  input wire logic clk,
  // management pins
  output logic mdc,
  output logic mdio_drive_en,
  output logic mdio_drive,
  input wire logic mdio_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // bus idles with clock low and line released to the pull-up
  initial begin
    mdc = 1'b0;
    mdio_drive_en = 1'b0;
    mdio_drive = 1'b0;
  end
  // one bit: set while mdc is low, read back just before the rise
  task automatic slot(input logic en, input logic b, output logic seen);
    @(posedge clk);
    mdc <= 1'b0;
    mdio_drive_en <= en;
    mdio_drive <= b;
    repeat (8) @(posedge clk);
    seen = mdio_line;
    mdc <= 1'b1;
    repeat (7) @(posedge clk);
  endtask
  // whole frame; the clock stands still low afterwards
  task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] addr,
      input logic [15:0] wdata, output logic [15:0] rdata);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'h1, op, phy, addr};
    wr = (op == 2'h1);
    for (int i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
    slot(wr, 1'b1, s);
    slot(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      slot(wr, wdata[i], s);
      rdata[i] = s;
    end
    @(posedge clk);
    mdc <= 1'b0;
    mdio_drive_en <= 1'b0;
  endtask
endmodule

// *** phy_mgmt_pkg.sv ***
/*
  constants, field positions and state codes shared by the management
  register block of the transceiver.
  assumes a single 100 MHz clock domain and a management clock that
  arrives on a pin and is sampled, not used as a clock.
*/
package phy_mgmt_pkg;

  // ==========================================
  // register addresses
  localparam logic [4:0] QUICK_POLL_DETAILED_STATUS = 5'h11;
  localparam logic [4:0] TENBASE_T_OPERATIONS = 5'h12;
  localparam logic [4:0] VENDOR_FIRST = 5'h19;
  localparam logic [4:0] VENDOR_LAST = 5'h1F;

  // ==========================================
  // management frame fields
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HDR_LAST = 5'h0B;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ==========================================
  // tenbase_t_operations field positions
  localparam int TBO_REMOTE_JABBER = 15;
  localparam int TBO_POLARITY = 14;
  localparam int TBO_BUS_MODE_LO = 12;
  localparam int TBO_AMDIX = 11;
  localparam int TBO_RX_FLOAT = 10;
  localparam int TBO_VENDOR_GATE = 9;
  localparam int TBO_TEST_MUX = 8;
  localparam int TBO_JABBER_INHIBIT = 5;
  localparam int TBO_FIXED_ONE = 4;

  // ==========================================
  // reset values
  localparam logic [2:0] PROGRESS_RESET = 3'h0;
  localparam logic [1:0] BUS_MODE_RESET = 2'h0;
  localparam logic [4:0] PHY_ADDR_RESET = 5'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // one-hot frame decoder states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_START = 7'h02,
    ST_HEADER = 7'h04,
    ST_TURN = 7'h08,
    ST_READ = 7'h10,
    ST_WRITE = 7'h20,
    ST_SKIP = 7'h40
  } frame_state_t;

endpackage

// *** phy_status_and_tenbase_control_regs.sv ***
/*
  management serial slave with the quick-poll detailed status register
  and the 10Base-T operations register of the transceiver.
  assumes status inputs come from datapath logic on clk, while the
  management clock, data pin and straps are asynchronous pins.
*/
// Summary of operation
// - status bit 11 shows progress bit 0, highest since last read, reset 0
// - status bit 8 latches false carrier until read
// - status bit 6 latches halt symbol reception until read, reset 0
// - status bit 5 latches two consecutive idle symbols inside a frame
// - status bit 1 latches remote fault until read, reset 0
// - operations bits 13:12 show strap-latched bus mode: 1x RMII, 01 serial, 00 MII
// - operations bit 10 set floats the receive outputs
// - vendor registers 25 to 31 reachable only while operations bit 9 is 0
// - operations bit 8 selects test mux source; 0 routes secondary onto primary
module phy_status_and_tenbase_control_regs
  import phy_mgmt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management serial pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // straps
  input wire logic [4:0] strap_phy_addr,
  input wire logic [1:0] strap_bus_mode,
  input wire logic strap_amdix,
  input wire logic strap_rx_float,
  input wire logic strap_vendor_gate,
  // datapath status
  input wire logic [2:0] an_progress,
  input wire logic signal_lost,
  input wire logic pll_lock_error,
  input wire logic false_carrier,
  input wire logic invalid_symbol,
  input wire logic halt_symbol,
  input wire logic rx_in_frame,
  input wire logic rx_symbol_strobe,
  input wire logic rx_symbol_idle,
  input wire logic an_complete,
  input wire logic no_signal,
  input wire logic jabber,
  input wire logic remote_fault,
  input wire logic link_up,
  input wire logic remote_jabber,
  input wire logic polarity_reversed,
  // vendor register port
  input wire logic [15:0] vendor_rdata,
  output logic vendor_write,
  output logic [4:0] vendor_addr,
  output logic [15:0] vendor_wdata,
  // controls
  output logic receive_output_float,
  output logic vendor_register_gate,
  output logic test_mux_select,
  output logic amdix_enable,
  output logic jabber_inhibit,
  // test multiplexer
  input wire logic test_mux_secondary,
  input wire logic test_internal,
  output logic test_mux_primary
);

  typedef struct packed {
    frame_state_t st;
    logic [5:0] pre;
    logic [4:0] cnt;
    logic [11:0] hdr;
    logic [15:0] sh;
    logic is_read;
    logic mdc_d;
    logic mdio_out;
    logic mdio_oe_n;
    logic [2:0] prog;
    logic sig_lost;
    logic pll_err;
    logic false_car;
    logic inv_sym;
    logic halt;
    logic prem;
    logic prev_idle;
    logic jab;
    logic rfault;
    logic link;
    logic rjab;
    logic pol;
    logic amdix;
    logic rx_float;
    logic gate;
    logic tm_sel;
    logic jab_inh;
    logic [1:0] bus_mode;
    logic [4:0] phyad;
    logic [1:0] cap_cnt;
    logic cap_done;
    logic tm_primary;
    logic vend_wr;
    logic [4:0] vend_addr;
    logic [15:0] vend_wdata;
  } regs_state_t;

  regs_state_t q_reg;
  regs_state_t q_next;
  logic [1:0] mgmt_s;
  logic [9:0] strap_s;

  // ==========================================
  // pin synchronisers
  pin_sync #(.W(2)) u_mgmt_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({mdc, mdio_in}),
    .sync(mgmt_s)
  );

  pin_sync #(.W(10)) u_strap_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin({strap_phy_addr, strap_bus_mode, strap_amdix, strap_rx_float, strap_vendor_gate}),
    .sync(strap_s)
  );

  // ==========================================
  // next-state logic
  always_comb begin
    logic rise;
    logic bit_in;
    logic rd_clear;
    logic [11:0] hdr_new;
    logic [4:0] regad;
    logic [15:0] rdata;
    q_next = q_reg;
    rdata = DATA_RESET;
    rise = mgmt_s[1] & ~q_reg.mdc_d;
    bit_in = mgmt_s[0];
    rd_clear = 1'b0;
    hdr_new = {q_reg.hdr[10:0], bit_in};
    regad = q_reg.hdr[4:0];
    q_next.mdc_d = mgmt_s[1];
    q_next.vend_wr = 1'b0;

    // read data, assembled from current state before any clear
    if (regad == QUICK_POLL_DETAILED_STATUS) begin
      rdata[11] = q_reg.prog[0];
      rdata[10] = q_reg.sig_lost;
      rdata[9] = q_reg.pll_err;
      rdata[8] = q_reg.false_car;
      rdata[7] = q_reg.inv_sym;
      rdata[6] = q_reg.halt;
      rdata[5] = q_reg.prem;
      rdata[4] = an_complete;
      rdata[3] = no_signal;
      rdata[2] = q_reg.jab;
      rdata[1] = q_reg.rfault;
      rdata[0] = q_reg.link;
    end else if (regad == TENBASE_T_OPERATIONS) begin
      rdata[TBO_REMOTE_JABBER] = q_reg.rjab;
      rdata[TBO_POLARITY] = q_reg.pol;
      rdata[TBO_BUS_MODE_LO+1:TBO_BUS_MODE_LO] = q_reg.bus_mode;
      rdata[TBO_AMDIX] = q_reg.amdix;
      rdata[TBO_RX_FLOAT] = q_reg.rx_float;
      rdata[TBO_VENDOR_GATE] = q_reg.gate;
      rdata[TBO_TEST_MUX] = q_reg.tm_sel;
      rdata[TBO_JABBER_INHIBIT] = q_reg.jab_inh;
      rdata[TBO_FIXED_ONE] = 1'b1;
    end else if (regad >= VENDOR_FIRST && !q_reg.gate) begin
      rdata = vendor_rdata;
    end

    // ==========================================
    // frame decoder, advanced on each management clock rise
    if (rise) begin
      case (q_reg.st)
        ST_IDLE: begin
          if (bit_in) begin
            q_next.pre = (q_reg.pre == PREAMBLE_LEN) ? q_reg.pre : q_reg.pre + 6'h01;
          end else begin
            q_next.st = (q_reg.pre == PREAMBLE_LEN) ? ST_START : ST_IDLE;
            q_next.pre = '0;
          end
        end
        ST_START: begin
          q_next.st = bit_in ? ST_HEADER : ST_IDLE;
          q_next.cnt = '0;
        end
        ST_HEADER: begin
          q_next.hdr = hdr_new;
          q_next.cnt = q_reg.cnt + 5'h01;
          if (q_reg.cnt == HDR_LAST) begin
            q_next.cnt = '0;
            q_next.is_read = (hdr_new[11:10] == OP_READ);
            // frames for another address or unknown opcodes are skipped
            if (hdr_new[9:5] != q_reg.phyad || !q_reg.cap_done) begin
              q_next.st = ST_SKIP;
            end else if (hdr_new[11:10] == OP_READ || hdr_new[11:10] == OP_WRITE) begin
              q_next.st = ST_TURN;
            end else begin
              q_next.st = ST_SKIP;
            end
          end
        end
        ST_TURN: begin
          q_next.cnt = q_reg.cnt + 5'h01;
          if (q_reg.cnt == 5'h00) begin
            // second turnaround bit is driven low on reads
            q_next.mdio_oe_n = ~q_reg.is_read;
            q_next.mdio_out = 1'b0;
          end else begin
            q_next.cnt = '0;
            if (q_reg.is_read) begin
              q_next.st = ST_READ;
              q_next.sh = {rdata[14:0], 1'b0};
              q_next.mdio_out = rdata[15];
              rd_clear = (regad == QUICK_POLL_DETAILED_STATUS);
            end else begin
              q_next.st = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          q_next.cnt = q_reg.cnt + 5'h01;
          q_next.mdio_out = q_reg.sh[15];
          q_next.sh = {q_reg.sh[14:0], 1'b0};
          if (q_reg.cnt == DATA_LAST) begin
            q_next.st = ST_IDLE;
            q_next.mdio_oe_n = 1'b1;
            q_next.mdio_out = 1'b0;
          end
        end
        ST_WRITE: begin
          q_next.cnt = q_reg.cnt + 5'h01;
          q_next.sh = {q_reg.sh[14:0], bit_in};
          if (q_reg.cnt == DATA_LAST) begin
            q_next.st = ST_IDLE;
            if (regad == TENBASE_T_OPERATIONS) begin
              q_next.amdix = q_reg.sh[14 - (15 - TBO_AMDIX)];
              q_next.rx_float = q_reg.sh[14 - (15 - TBO_RX_FLOAT)];
              q_next.gate = q_reg.sh[14 - (15 - TBO_VENDOR_GATE)];
              q_next.tm_sel = q_reg.sh[14 - (15 - TBO_TEST_MUX)];
              q_next.jab_inh = q_reg.sh[14 - (15 - TBO_JABBER_INHIBIT)];
            end else if (regad >= VENDOR_FIRST && regad <= VENDOR_LAST && !q_reg.gate) begin
              q_next.vend_wr = 1'b1;
              q_next.vend_addr = regad;
              q_next.vend_wdata = {q_reg.sh[14:0], bit_in};
            end
          end
        end
        ST_SKIP: begin
          // wait out turnaround and data without driving
          q_next.cnt = q_reg.cnt + 5'h01;
          if (q_reg.cnt == DATA_LAST + 5'h02) begin
            q_next.st = ST_IDLE;
          end
        end
        default: begin
          q_next.st = ST_IDLE;
          q_next.mdio_oe_n = 1'b1;
        end
      endcase
    end

    // ==========================================
    // latched status; a new event wins over a read clear
    q_next.prog = (rd_clear || an_progress > q_reg.prog) ? an_progress : q_reg.prog;
    q_next.sig_lost = signal_lost | (q_reg.sig_lost & ~rd_clear);
    q_next.pll_err = pll_lock_error | (q_reg.pll_err & ~rd_clear);
    q_next.false_car = false_carrier | (q_reg.false_car & ~rd_clear);
    q_next.inv_sym = invalid_symbol | (q_reg.inv_sym & ~rd_clear);
    q_next.halt = halt_symbol | (q_reg.halt & ~rd_clear);
    q_next.jab = jabber | (q_reg.jab & ~rd_clear);
    q_next.rfault = remote_fault | (q_reg.rfault & ~rd_clear);
    q_next.rjab = remote_jabber | (q_reg.rjab & ~rd_clear);
    q_next.pol = polarity_reversed | (q_reg.pol & ~rd_clear);
    q_next.link = rd_clear ? link_up : (q_reg.link & link_up);

    // premature end: two idle symbols in a row while a frame is open
    q_next.prem = q_reg.prem & ~rd_clear;
    if (!rx_in_frame) begin
      q_next.prev_idle = 1'b0;
    end else if (rx_symbol_strobe) begin
      q_next.prev_idle = rx_symbol_idle;
      if (rx_symbol_idle && q_reg.prev_idle) begin
        q_next.prem = 1'b1;
      end
    end

    // ==========================================
    // straps caught a few cycles after reset, once synchronised
    if (!q_reg.cap_done) begin
      q_next.cap_cnt = q_reg.cap_cnt + 2'h1;
      if (q_reg.cap_cnt == STRAP_SETTLE) begin
        q_next.cap_done = 1'b1;
        q_next.phyad = strap_s[9:5];
        q_next.bus_mode = strap_s[4:3];
        q_next.amdix = strap_s[2];
        q_next.rx_float = strap_s[1];
        q_next.gate = strap_s[0];
      end
    end

    // test mux: 0 passes the secondary line onto the primary
    q_next.tm_primary = q_reg.tm_sel ? test_internal : test_mux_secondary;
  end

  // ==========================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.mdio_oe_n <= 1'b1;
      q_reg.prog <= PROGRESS_RESET;
      q_reg.bus_mode <= BUS_MODE_RESET;
      q_reg.phyad <= PHY_ADDR_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================
  // outputs, all straight from the state register
  assign mdio_out = q_reg.mdio_out;
  assign mdio_oe_n = q_reg.mdio_oe_n;
  assign vendor_write = q_reg.vend_wr;
  assign vendor_addr = q_reg.vend_addr;
  assign vendor_wdata = q_reg.vend_wdata;
  assign receive_output_float = q_reg.rx_float;
  assign vendor_register_gate = q_reg.gate;
  assign test_mux_select = q_reg.tm_sel;
  assign amdix_enable = q_reg.amdix;
  assign jabber_inhibit = q_reg.jab_inh;
  assign test_mux_primary = q_reg.tm_primary;

endmodule

// *** phy_status_and_tenbase_control_regs_monitor.sv ***
/*
  checker for the management register block, bound to its top module.
  assumes mdc runs at 16 clk a period and straps stay still after reset.
*/
module phy_status_and_tenbase_control_regs_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic vendor_write,
  input wire logic receive_output_float,
  input wire logic vendor_register_gate,
  input wire logic test_mux_select,
  input wire logic test_mux_secondary,
  input wire logic test_internal,
  input wire logic test_mux_primary
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] up_reg;
  logic [4:0] rise_reg;
  // ======
  // helpers: settle count after reset, pin rises seen while answering
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_reg <= 2'h0;
      rise_reg <= 5'h00;
    end else begin
      if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
      if (mdio_oe_n) rise_reg <= 5'h00;
      else if (mdc && !$past(mdc)) rise_reg <= rise_reg + 5'h01;
    end
  end
  // ======
  // sequences
  sequence s_sec_path;
    up_reg == 2'h3 && !test_mux_select ##1 !test_mux_select;
  endsequence
  sequence s_int_path;
    up_reg == 2'h3 && test_mux_select ##1 test_mux_select;
  endsequence
  sequence s_drive_rise;
    up_reg == 2'h3 && !mdio_oe_n && $rose(mdc);
  endsequence
  // ======
  // properties
  property p_mux_sec;
    s_sec_path |-> test_mux_primary == $past(test_mux_secondary);
  endproperty
  property p_mux_int;
    s_int_path |-> test_mux_primary == $past(test_internal);
  endproperty
  property p_float_quiet;
    !mdio_oe_n && !$past(mdio_oe_n) |-> $stable(receive_output_float);
  endproperty
  property p_gate_quiet;
    !mdio_oe_n && !$past(mdio_oe_n) |-> $stable(vendor_register_gate);
  endproperty
  property p_vendor_block;
    vendor_write |-> !vendor_register_gate;
  endproperty
  property p_vendor_single;
    vendor_write |=> !vendor_write;
  endproperty
  property p_first_zero;
    $fell(mdio_oe_n) |-> !mdio_out;
  endproperty
  property p_read_len;
    $rose(mdio_oe_n) |-> rise_reg == 5'h11;
  endproperty
  property p_out_stand;
    s_drive_rise |-> ##6 ($stable(mdio_out) || mdio_oe_n) [*8];
  endproperty
  a_mux_sec: assert property (p_mux_sec) else $error("secondary not on primary");
  a_mux_int: assert property (p_mux_int) else $error("internal not on primary");
  a_float_quiet: assert property (p_float_quiet) else $error("float moved in read");
  a_gate_quiet: assert property (p_gate_quiet) else $error("gate moved in read");
  a_vendor_block: assert property (p_vendor_block) else $error("vendor write gated");
  a_vendor_single: assert property (p_vendor_single) else $error("vendor strobe long");
  a_first_zero: assert property (p_first_zero) else $error("turnaround not 0");
  a_read_len: assert property (p_read_len) else $error("answer length wrong");
  a_out_stand: assert property (p_out_stand) else $error("data bit unsteady");
endmodule
bind phy_status_and_tenbase_control_regs phy_status_and_tenbase_control_regs_monitor mon_u (
  .clk, .rst_n, .mdc, .mdio_out, .mdio_oe_n, .vendor_write, .receive_output_float,
  .vendor_register_gate, .test_mux_select, .test_mux_secondary, .test_internal,
  .test_mux_primary);

// *** phy_status_and_tenbase_control_regs_tb.sv ***
/*
  self-checking bench for the management register block.
  assumes the station model and the bound checker from their own files.
*/
module phy_status_and_tenbase_control_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_mgmt_pkg::*;
  logic clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe_n, mdio_drive_en, mdio_drive;
  logic [4:0] strap_phy_addr, vendor_addr;
  logic [1:0] strap_bus_mode;
  logic strap_amdix, strap_rx_float, strap_vendor_gate, vendor_write;
  logic [2:0] an_progress;
  logic signal_lost, pll_lock_error, false_carrier, invalid_symbol, halt_symbol;
  logic rx_in_frame, rx_symbol_strobe, rx_symbol_idle, an_complete, no_signal;
  logic jabber, remote_fault, link_up, remote_jabber, polarity_reversed;
  logic [15:0] vendor_rdata, vendor_wdata, rd, vw, ctl;
  logic receive_output_float, vendor_register_gate, test_mux_select, amdix_enable;
  logic jabber_inhibit, test_mux_secondary, test_internal, test_mux_primary;
  int err_total, compares, lh, prog, link_lat, m;
  int wr_pulses = 0;
  // ======
  // clock, pulled-up data line, far side and design
  initial clk = 1'b0;
  always #5 clk = ~clk;
  assign mdio_in = !mdio_oe_n ? mdio_out : (mdio_drive_en ? mdio_drive : 1'b1);
  mgmt_station_model model_u (.clk, .mdc, .mdio_drive_en, .mdio_drive, .mdio_line(mdio_in));
  phy_status_and_tenbase_control_regs dut_u (.clk, .rst_n, .mdc, .mdio_in, .mdio_out,
    .mdio_oe_n, .strap_phy_addr, .strap_bus_mode, .strap_amdix, .strap_rx_float,
    .strap_vendor_gate, .an_progress, .signal_lost, .pll_lock_error, .false_carrier,
    .invalid_symbol, .halt_symbol, .rx_in_frame, .rx_symbol_strobe, .rx_symbol_idle,
    .an_complete, .no_signal, .jabber, .remote_fault, .link_up, .remote_jabber,
    .polarity_reversed, .vendor_rdata, .vendor_write, .vendor_addr, .vendor_wdata,
    .receive_output_float, .vendor_register_gate, .test_mux_select, .amdix_enable,
    .jabber_inhibit, .test_mux_secondary, .test_internal, .test_mux_primary);
  // random mux sources each cycle; count vendor write pulses
  always @(posedge clk) begin
    test_mux_secondary <= 1'($urandom);
    test_internal <= 1'($urandom);
    if (vendor_write === 1'b1) wr_pulses <= wr_pulses + 1;
  end
  // ======
  // reporting
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ======
  // transfers and the status model
  task automatic xfer(input logic [1:0] op, input logic [4:0] addr, input logic [15:0] w);
    model_u.frame(strap_phy_addr, op, addr, w, rd);
  endtask
  task automatic read_status();
    xfer(OP_READ, QUICK_POLL_DETAILED_STATUS, 16'h0000);
    check("status", rd, 16'(((prog & 1) << 11) | lh | (an_complete << 4)
      | (no_signal << 3) | link_lat));
    lh = remote_fault ? 2 : 0;
    prog = an_progress;
    link_lat = link_up;
  endtask
  task automatic read_ops();
    xfer(OP_READ, TENBASE_T_OPERATIONS, 16'h0000);
    check("operations", rd, {2'h0, strap_bus_mode, 12'h010} | ctl);
    check("controls", {11'h000, amdix_enable, receive_output_float, vendor_register_gate,
      test_mux_select, jabber_inhibit}, {11'h000, ctl[11:8], ctl[5]});
  endtask
  task automatic write_ops(input logic [15:0] w);
    xfer(OP_WRITE, TENBASE_T_OPERATIONS, w);
    ctl = w & 16'h0F20;
  endtask
  // straps change only while reset is held
  task automatic do_reset(input logic [1:0] mode);
    @(posedge clk);
    rst_n <= 1'b0;
    strap_bus_mode <= mode;
    strap_amdix <= 1'($urandom);
    strap_rx_float <= 1'($urandom);
    strap_vendor_gate <= 1'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    ctl = {4'h0, strap_amdix, strap_rx_float, strap_vendor_gate, 9'h000};
    lh = 0;
    prog = 0;
    link_lat = 0;
  endtask
  task automatic raise_events(input int f);
    @(posedge clk);
    {signal_lost, pll_lock_error, false_carrier, invalid_symbol, halt_symbol} <= f[10:6];
    {jabber, remote_fault} <= f[2:1];
    @(posedge clk);
    {signal_lost, pll_lock_error, false_carrier, invalid_symbol, halt_symbol} <= 5'h00;
    {jabber, remote_fault} <= 2'h0;
    lh |= f;
  endtask
  // four received symbols inside a frame, idle flags msb first
  task automatic symbols(input logic [3:0] idl);
    @(posedge clk) rx_in_frame <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk);
      rx_symbol_strobe <= 1'b1;
      rx_symbol_idle <= idl[i];
      @(posedge clk);
      rx_symbol_strobe <= 1'b0;
    end
    @(posedge clk) rx_in_frame <= 1'b0;
  endtask
  task automatic set_prog(input logic [2:0] v);
    @(posedge clk);
    an_progress <= v;
    if (v > prog) prog = v;
  endtask
  // ======
  // main sequence
  initial begin
    void'($urandom(17));
    err_total = 0;
    compares = 0;
    rst_n = 1'b0;
    strap_phy_addr = 5'($urandom);
    {strap_bus_mode, strap_amdix, strap_rx_float, strap_vendor_gate} = 5'h00;
    {an_progress, signal_lost, pll_lock_error, false_carrier, invalid_symbol} = 7'h00;
    {halt_symbol, rx_in_frame, rx_symbol_strobe, rx_symbol_idle, jabber} = 5'h00;
    {remote_fault, link_up, remote_jabber, polarity_reversed} = 4'h0;
    {an_complete, no_signal} = 2'h3;
    vendor_rdata = 16'($urandom);
    for (m = 0; m < 4; m++) begin
      do_reset(2'(m));
      read_ops();
    end
    read_status();
    raise_events(32'h000007C6);
    // skipped frames leave the line to the pull-up and must not clear flags
    model_u.frame(strap_phy_addr ^ 5'h01, OP_READ, QUICK_POLL_DETAILED_STATUS, 16'h0000, rd);
    check("foreign address", rd, 16'hFFFF);
    model_u.frame(strap_phy_addr, 2'h3, QUICK_POLL_DETAILED_STATUS, 16'h0000, rd);
    check("unknown opcode", rd, 16'hFFFF);
    read_status();
    read_status();
    @(posedge clk) remote_fault <= 1'b1;
    lh |= 2;
    read_status();
    @(posedge clk) remote_fault <= 1'b0;
    read_status();
    read_status();
    symbols(4'hA);
    read_status();
    symbols(4'h6);
    lh |= 32;
    read_status();
    set_prog(3'h3);
    set_prog(3'h2);
    read_status();
    read_status();
    @(posedge clk) link_up <= 1'b1;
    read_status();
    read_status();
    @(posedge clk) link_up <= 1'b0;
    link_lat = 0;
    @(posedge clk) link_up <= 1'b1;
    read_status();
    read_status();
    for (m = 0; m < 3; m++) begin
      write_ops((16'($urandom) & 16'hFEFF) | (m == 1 ? 16'h0100 : 16'h0000));
      read_ops();
    end
    write_ops(16'h0000);
    read_ops();
    vw = 16'($urandom);
    xfer(OP_WRITE, VENDOR_FIRST + 5'h01, vw);
    check("vendor pulses", 16'(wr_pulses), 16'h0001);
    check("vendor addr", 16'(vendor_addr), 16'h001A);
    check("vendor data", vendor_wdata, vw);
    xfer(OP_READ, VENDOR_LAST, 16'h0000);
    check("vendor read", rd, vendor_rdata);
    write_ops(16'h0200);
    xfer(OP_WRITE, VENDOR_FIRST, ~vw);
    check("gated pulses", 16'(wr_pulses), 16'h0001);
    xfer(OP_READ, VENDOR_LAST, 16'h0000);
    check("gated read", rd, 16'h0000);
    conclude();
  end
  // watchdog: the run needs about 34000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule

// *** pin_sync.sv ***
/*
  two-stage synchroniser for a group of pin inputs.
  assumes the inputs are slow or static relative to clk; each bit is
  synchronised on its own, so multi-bit groups must be quasi-static.
*/
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and synchronised copy
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t q_reg;
  sync_state_t q_next;

  // ==========================================
  // first stage feeds only the second stage
  always_comb begin
    q_next = q_reg;
    q_next.s1 = pin;
    q_next.s2 = q_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign sync = q_reg.s2;

endmodule
